// ===== eep_pkg.sv
`default_nettype none
package eep_pkg;
  // memory geometry
  localparam int          ADDR_W     = 13;
  localparam int          PAGE_W     = 5;
  localparam int          PAGE_BYTES = 32;
  localparam int          MEM_DEPTH  = 8192;
  localparam int          HI_BITS    = 5;
  localparam int          SEL_W      = 3;
  localparam int          TYPE_W     = 4;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  // slave-address field positions
  localparam int          TYPE_LSB   = 4;
  localparam int          SEL_LSB    = 1;
  localparam int          RW_BIT     = 0;
  // clock periods
  localparam int          REF_PERIOD_NS  = 40;
  localparam int          LINK_PERIOD_NS = 30;
  // glitch suppression: samples needed, one more than a pulse just under
  // the limit can show, so such a pulse never reaches the protocol logic
  localparam int          FILT_W         = 3;
  localparam int          GLITCH_STD_NS  = 100;
  localparam int          GLITCH_FAST_NS = 50;
  localparam logic [FILT_W-1:0] GLITCH_STD_CLKS =
    FILT_W'((GLITCH_STD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1);
  localparam logic [FILT_W-1:0] GLITCH_FAST_CLKS =
    FILT_W'((GLITCH_FAST_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1);
  // program_cycle_time, longest time rounded down to ref cycles
  localparam int          PROGRAM_CYCLE_TIME_MS = 10;
  localparam int          PROGRAM_CYCLE_CLKS    =
    (PROGRAM_CYCLE_TIME_MS * 1000000) / REF_PERIOD_NS;
  localparam int          TMR_W = 32;
  // reset value of filtered pins (idle bus is high)
  localparam logic        FILT_RST = 1'b1;
  // protocol states
  typedef enum logic [5:0] {
    S_IDLE    = 6'b00_0001,
    S_RX      = 6'b00_0010,
    S_ACK_OUT = 6'b00_0100,
    S_TX      = 6'b00_1000,
    S_ACK_IN  = 6'b01_0000,
    S_IGNORE  = 6'b10_0000
  } eep_state_t;
  // byte position within a transaction
  typedef enum logic [3:0] {
    PH_DEV  = 4'b0001,
    PH_HI   = 4'b0010,
    PH_LO   = 4'b0100,
    PH_DATA = 4'b1000
  } eep_phase_t;
endpackage : eep_pkg
`default_nettype wire

// ===== eep_bus_filt.sv
`default_nettype none
module eep_bus_filt #(
  parameter int   W    = 3,
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // pin and filter length
  input  wire logic [W-1:0] i_len,
  input  wire logic         i_pin,
  // filtered level
  output logic              o_level
);
  logic         s1_q;
  logic         s2_q;
  logic [W-1:0] cnt_q;

  // two-stage synchroniser, nothing reads s1_q but s2_q
  always_ff @(posedge i_clk) begin
    s1_q <= i_pin;
    s2_q <= s1_q;
  end

  // a new level is taken only after it stood i_len samples
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      o_level <= INIT;
    end else if (s2_q == o_level) begin
      cnt_q <= '0;
    end else if (cnt_q == i_len - 1'b1) begin
      cnt_q   <= '0;
      o_level <= s2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : eep_bus_filt
`default_nettype wire

// ===== eep_mem.sv
`default_nettype none
module eep_mem #(
  parameter int AW    = 13,
  parameter int DW    = 8,
  parameter int DEPTH = 8192
) (
  // clock
  input  wire logic          i_clk,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [DEPTH];

  // byte array, written one location per cycle
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // asynchronous read
  assign o_rdata = mem_q[i_raddr];
endmodule : eep_mem
`default_nettype wire

// ===== eep_i2c_slave.sv
`default_nettype none
// Summary of operation
// - sda falling while scl high is a start and opens a transaction
// - all bus activity is ignored until a valid start is seen
// - sda rising while scl high is a stop and ends the transaction
// - a stop returns the device to standby unless programming was launched
// - sda changes only while scl is low, except start and stop
// - exchanges run start to stop, the receiver acknowledges every byte it accepts
// - the top nibble of the address byte must hold the device type
// - the next three bits must match the device select straps
// - last address bit one means read, zero means write
// - a page write programs up to 32 bytes in one cycle
// - programming starts at the write stop and ends within the cycle time
// - while programming the bus is ignored and sda stays released
// - pulses shorter than 100 ns, or 50 ns in fast mode, are ignored
// - with protect high, upper-half writes are not programmed, reads stay allowed
// - with protect low, the whole array is readable and writable
// - protected write: addresses acknowledged, data bytes not acknowledged
// - sda is only pulled low, as an open-drain output
// - after eight bits the receiver pulls sda low on the ninth clock
// - word address has 13 bits, five from the high byte
// - page writes increment and wrap inside the page
// - reads continue while the master acknowledges, stop on no acknowledge
module eep_i2c_slave #(
  parameter int unsigned P_PROGRAM_CYCLE_CLKS = eep_pkg::PROGRAM_CYCLE_CLKS,
  parameter logic [3:0]  P_DEV_TYPE           = 4'h6  // arbitrary type code
) (
  // clocks and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_link_clk,
  // two-wire bus
  input  wire logic                      i_scl,
  input  wire logic                      i_sda,
  output logic                           o_sda_o,
  output logic                           o_sda_oe_n,
  // straps and control pins
  input  wire logic [eep_pkg::SEL_W-1:0] i_device_select_straps,
  input  wire logic                      i_write_protect,
  input  wire logic                      i_fast_mode,
  // status
  output logic                           o_busy,
  output logic                           o_standby
);
  import eep_pkg::*;

  localparam int NIN = SEL_W + 4;

  logic                 lrst_s1_q;
  logic                 lrst_s2_q;
  logic [NIN-1:0]       filt;
  logic                 scl_q;
  logic                 sda_q;
  eep_state_t           state_q;
  eep_phase_t           phase_q;
  logic [3:0]           cnt_q;
  logic [7:0]           sh_q;
  logic [7:0]           tx_q;
  logic                 rw_q;
  logic                 pend_q;
  logic                 mack_q;
  logic                 oe_n_q;
  logic                 sda_o_q;
  logic                 standby_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [HI_BITS-1:0]   hi_q;
  logic [7:0]           page_buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_q;
  logic                 commit_q;
  logic [PAGE_W-1:0]    cidx_q;
  logic                 req_tgl_q;
  logic                 hold_q;
  logic                 busy_s1_q;
  logic                 busy_s2_q;
  logic                 req_s1_q;
  logic                 req_s2_q;
  logic                 req_s3_q;
  logic                 busy_ref_q;
  logic [TMR_W-1:0]     tmr_q;
  logic [7:0]           rd_byte;

  // link-domain reset, released in step with the link clock
  always_ff @(posedge i_link_clk) begin
    lrst_s1_q <= i_resetn;
    lrst_s2_q <= lrst_s1_q;
  end
  wire logic lrst_n = lrst_s2_q;

  // every pin is synchronised and filtered; fast mode shortens the filter
  wire logic [NIN-1:0] raw_in = {i_fast_mode, i_write_protect, i_device_select_straps,
                                 i_sda, i_scl};
  wire logic [FILT_W-1:0] flen = filt[NIN-1] ? GLITCH_FAST_CLKS : GLITCH_STD_CLKS;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_filt
      eep_bus_filt #(
        .W    (FILT_W),
        .INIT (FILT_RST)
      ) u_filt (
        .i_clk   (i_link_clk),
        .i_rst_n (lrst_n),
        .i_len   (flen),
        .i_pin   (raw_in[gi]),
        .o_level (filt[gi])
      );
    end
  endgenerate

  // filtered levels
  wire logic             scl = filt[0];
  wire logic             sda = filt[1];
  wire logic [SEL_W-1:0] sel = filt[SEL_W+1:2];
  wire logic             wp  = filt[SEL_W+2];

  // bus events from the filtered samples
  wire logic scl_rise = scl & ~scl_q;
  wire logic scl_fall = ~scl & scl_q;
  wire logic start_ev = scl & scl_q & sda_q & ~sda;
  wire logic stop_ev  = scl & scl_q & ~sda_q & sda;

  // byte decisions
  wire logic busy_link  = hold_q | busy_s2_q | commit_q;
  wire logic type_ok    = sh_q[TYPE_LSB +: TYPE_W] == P_DEV_TYPE;
  wire logic sel_ok     = sh_q[SEL_LSB +: SEL_W] == sel;
  wire logic addr_match = type_ok & sel_ok & ~busy_link;
  wire logic wr_protect = wp & addr_q[ADDR_W-1];
  wire logic rx_ack     = (phase_q == PH_DEV)  ? addr_match :
                          (phase_q == PH_DATA) ? ~wr_protect : 1'b1;
  wire logic byte_done  = scl_fall & (cnt_q == BYTE_BITS);
  wire logic launch     = stop_ev & pend_q & ~busy_link;
  wire logic mem_we     = commit_q & page_vld_q[cidx_q];
  wire logic [ADDR_W-1:0] mem_waddr = {addr_q[ADDR_W-1:PAGE_W], cidx_q};

  // previous filtered levels for edge detection
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // protocol engine; start and stop override every state
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      state_q    <= S_IDLE;
      phase_q    <= PH_DEV;
      cnt_q      <= '0;
      sh_q       <= '0;
      tx_q       <= '0;
      rw_q       <= 1'b0;
      pend_q     <= 1'b0;
      mack_q     <= 1'b0;
      oe_n_q     <= 1'b1;
      addr_q     <= '0;
      hi_q       <= '0;
      page_vld_q <= '0;
    end else if (start_ev) begin
      state_q <= busy_link ? S_IGNORE : S_RX;
      phase_q <= PH_DEV;
      cnt_q   <= '0;
      pend_q  <= 1'b0;  // a repeated start drops an unfinished write
      oe_n_q  <= 1'b1;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
      pend_q  <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      unique case (state_q)
        S_IDLE, S_IGNORE: begin
          oe_n_q <= 1'b1;
        end
        S_RX: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda};
            cnt_q <= cnt_q + 1'b1;
          end else if (byte_done) begin
            cnt_q   <= '0;
            state_q <= rx_ack ? S_ACK_OUT : S_IGNORE;
            oe_n_q  <= ~rx_ack;
            unique case (phase_q)
              PH_DEV: begin
                rw_q    <= sh_q[RW_BIT];
                phase_q <= sh_q[RW_BIT] ? PH_DATA : PH_HI;
              end
              PH_HI: begin
                hi_q    <= sh_q[HI_BITS-1:0];
                phase_q <= PH_LO;
              end
              PH_LO: begin
                addr_q     <= {hi_q, sh_q};
                page_vld_q <= '0;
                phase_q    <= PH_DATA;
              end
              PH_DATA: begin
                if (rx_ack) begin
                  page_buf_q[addr_q[PAGE_W-1:0]] <= sh_q;
                  page_vld_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                  addr_q <= {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 1'b1};
                  pend_q <= 1'b1;
                end else begin
                  pend_q <= 1'b0;
                end
              end
            endcase
          end
        end
        S_ACK_OUT: begin
          if (scl_fall) begin
            if (rw_q) begin
              oe_n_q  <= rd_byte[7];
              tx_q    <= {rd_byte[6:0], 1'b0};
              cnt_q   <= 4'h1;
              state_q <= S_TX;
            end else begin
              oe_n_q  <= 1'b1;
              state_q <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == BYTE_BITS) begin
              oe_n_q  <= 1'b1;
              cnt_q   <= '0;
              addr_q  <= addr_q + 1'b1;
              state_q <= S_ACK_IN;
            end else begin
              oe_n_q <= tx_q[7];
              tx_q   <= {tx_q[6:0], 1'b0};
              cnt_q  <= cnt_q + 1'b1;
            end
          end
        end
        S_ACK_IN: begin
          if (scl_rise) begin
            mack_q <= ~sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              oe_n_q  <= rd_byte[7];
              tx_q    <= {rd_byte[6:0], 1'b0};
              cnt_q   <= 4'h1;
              state_q <= S_TX;
            end else begin
              state_q <= S_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // page commit into the array, one slot per link cycle
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      commit_q <= 1'b0;
      cidx_q   <= '0;
    end else if (launch) begin
      commit_q <= 1'b1;
      cidx_q   <= '0;
    end else if (commit_q) begin
      cidx_q <= cidx_q + 1'b1;
      if (cidx_q == PAGE_W'(PAGE_BYTES - 1)) begin
        commit_q <= 1'b0;
      end
    end
  end

  eep_mem #(
    .AW    (ADDR_W),
    .DW    (8),
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .i_clk   (i_link_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (page_buf_q[cidx_q]),
    .i_raddr (addr_q),
    .o_rdata (rd_byte)
  );

  // program request toggle; hold covers the gap until busy returns
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      req_tgl_q <= 1'b0;
      hold_q    <= 1'b0;
    end else if (launch) begin
      req_tgl_q <= ~req_tgl_q;
      hold_q    <= 1'b1;
    end else if (busy_s2_q) begin
      hold_q <= 1'b0;
    end
  end

  // busy level back into the link domain, and link outputs
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      standby_q <= 1'b1;
      sda_o_q   <= 1'b0;
    end else begin
      busy_s1_q <= busy_ref_q;
      busy_s2_q <= busy_s1_q;
      standby_q <= (state_q == S_IDLE) & ~busy_link;
      sda_o_q   <= 1'b0;
    end
  end

  // request toggle into the reference domain
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end
  wire logic req_edge = req_s2_q ^ req_s3_q;

  // self-timed program cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      busy_ref_q <= 1'b0;
      tmr_q      <= '0;
    end else if (req_edge) begin
      busy_ref_q <= 1'b1;
      tmr_q      <= '0;
    end else if (busy_ref_q) begin
      tmr_q <= tmr_q + 1'b1;
      if (tmr_q == TMR_W'(P_PROGRAM_CYCLE_CLKS - 1)) begin
        busy_ref_q <= 1'b0;
      end
    end
  end

  // outputs
  assign o_sda_o    = sda_o_q;
  assign o_sda_oe_n = oe_n_q;
  assign o_busy     = busy_ref_q;
  assign o_standby  = standby_q;
endmodule : eep_i2c_slave
`default_nettype wire

// ===== eep_i2c_asserts.sv
`default_nettype none
module eep_i2c_asserts #(
  parameter int unsigned P_PROGRAM_CYCLE_CLKS = 250000
) (
  // clocks and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_link_clk,
  // bus and pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe_n,
  input wire logic [eep_pkg::SEL_W-1:0] i_device_select_straps,
  input wire logic i_write_protect,
  input wire logic i_fast_mode,
  // status
  input wire logic o_busy,
  input wire logic o_standby
);
  import eep_pkg::*;
  // length of the running busy period in ref cycles
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  assign busy_cnt_d = o_busy ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) busy_cnt_q <= 32'h0000_0000;
    else busy_cnt_q <= busy_cnt_d;
  end
  // stop seen on the pins
  sequence s_stop;
    i_scl && !i_sda ##1 i_scl && i_sda;
  endsequence
  property p_drain;
    @(posedge i_link_clk) disable iff (!i_resetn) o_sda_o == 1'h0;
  endproperty
  a_drain: assert property (p_drain) else $error("sda driven high");
  property p_busy_len;
    @(posedge i_ref_clk) disable iff (!i_resetn) $fell(o_busy) |->
      busy_cnt_q >= P_PROGRAM_CYCLE_CLKS - 1 && busy_cnt_q <= P_PROGRAM_CYCLE_CLKS;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_busy_quiet;
    @(posedge i_link_clk) disable iff (!i_resetn) o_busy |-> o_sda_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
  property p_busy_stby;
    @(posedge i_ref_clk) disable iff (!i_resetn) o_busy [*5] |-> !o_standby;
  endproperty
  a_busy_stby: assert property (p_busy_stby) else $error("standby while busy");
  property p_edge_low;
    @(posedge i_link_clk) disable iff (!i_resetn) $changed(o_sda_oe_n) |-> !i_scl;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("sda moved, scl high");
  property p_ack_hold;
    @(posedge i_link_clk) disable iff (!i_resetn) $fell(o_sda_oe_n) |-> !o_sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit too short");
  property p_stop_idle;
    @(posedge i_link_clk) disable iff (!i_resetn) s_stop |-> ##[1:100] (o_standby || o_busy);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no standby");
  property p_idle_quiet;
    @(posedge i_link_clk) disable iff (!i_resetn) o_standby |-> o_sda_oe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("driven in standby");
endmodule : eep_i2c_asserts
bind eep_i2c_slave eep_i2c_asserts #(
  .P_PROGRAM_CYCLE_CLKS(P_PROGRAM_CYCLE_CLKS)
) eep_i2c_asserts_i (
  .i_ref_clk, .i_resetn, .i_link_clk, .i_scl, .i_sda, .o_sda_o, .o_sda_oe_n,
  .i_device_select_straps, .i_write_protect, .i_fast_mode, .o_busy, .o_standby
);
`default_nettype wire

// ===== eep_mst.sv
`default_nettype none
module eep_mst #(
  parameter int Q = 10
) (
  // bench clock and resolved data wire
  input  wire logic i_clk,
  input  wire logic i_sda,
  // open-drain drives, 1 releases
  output var logic  o_scl,
  output var logic  o_sda
);
  logic       glitch;
  logic [7:0] res;
  event       got;
  // bus idles high
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
    glitch = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  // start, also a repeated start from a low clock
  task automatic start();
    o_sda = 1'h1;
    tick(Q);
    o_scl = 1'h1;
    tick(Q);
    o_sda = 1'h0;
    tick(Q);
    o_scl = 1'h0;
    tick(Q);
  endtask : start
  task automatic stop();
    o_sda = 1'h0;
    tick(Q);
    o_scl = 1'h1;
    tick(Q);
    o_sda = 1'h1;
    tick(2 * Q);
  endtask : stop
  // one clock: data moves while low, optional short pulse, sample mid high
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    tick(4);
    o_scl = glitch;
    tick(1);
    o_scl = 1'h0;
    tick(Q - 5);
    o_scl = 1'h1;
    tick(Q);
    r = i_sda;
    tick(Q);
    o_scl = 1'h0;
    tick(Q);
  endtask : bitx
  // byte out msb first, ninth bit released for the acknowledge
  task automatic wr(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'h1, r);
    res = {7'h00, r};
    ->got;
  endtask : wr
  task automatic rd(input logic nack);
    logic [7:0] v;
    logic       r;
    for (int i = 0; i < 8; i++) begin
      bitx(1'h1, r);
      v = {v[6:0], r};
    end
    bitx(nack, r);
    res = v;
    ->got;
  endtask : rd
endmodule : eep_mst
`default_nettype wire

// ===== eep_i2c_slave_tb.sv
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module eep_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eep_pkg::*;
  localparam int         P  = 1000;
  localparam logic [3:0] DT = 4'h6; // arbitrary type code
  localparam logic [7:0] AK = 8'h00;
  localparam logic [7:0] NK = 8'h01;
  logic       i_ref_clk, i_link_clk, i_resetn, i_write_protect, i_fast_mode;
  logic [2:0] i_device_select_straps;
  logic       m_scl, m_sda, sda, o_sda_o, o_sda_oe_n, o_busy, o_standby;
  logic [7:0] expq[$];
  logic [7:0] rq[$];
  logic [7:0] d[34];
  logic [7:0] v;
  logic [7:0] nx;
  int         failures;
  int         num_checks;
  // wire with pull-up
  assign sda = m_sda & (o_sda_oe_n | o_sda_o);
  initial begin
    i_ref_clk = 1'h0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'h0;
    #7;
    forever #15 i_link_clk = ~i_link_clk;
  end
  eep_i2c_slave #(.P_PROGRAM_CYCLE_CLKS(P), .P_DEV_TYPE(DT)) eep_i2c_slave_i (
    .i_ref_clk, .i_resetn, .i_link_clk, .i_scl(m_scl), .i_sda(sda), .o_sda_o,
    .o_sda_oe_n, .i_device_select_straps, .i_write_protect, .i_fast_mode, .o_busy,
    .o_standby);
  eep_mst #(.Q(10)) eep_mst_i (.i_clk(i_ref_clk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  // compare each finished byte with the oldest note
  initial begin
    forever begin
      @(eep_mst_i.got);
      `CHK(expq.size() > 0, 1'h1)
      nx = expq.pop_front();
      `CHK(eep_mst_i.res, nx)
    end
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    failures++;
    $display("CHECK FAILED at %0t: timeout", $time);
    finish_test();
  end
  task automatic send(input logic [7:0] b, input logic [7:0] e);
    expq.push_back(e);
    eep_mst_i.wr(b);
  endtask : send
  function automatic logic [7:0] dev(input logic rw);
    return {DT, i_device_select_straps, rw};
  endfunction : dev
  // dummy write of the word address, repeated start, read rq back
  task automatic rd(input logic [12:0] a);
    eep_mst_i.start();
    send(dev(1'h0), AK);
    send({3'h0, a[12:8]}, AK);
    send(a[7:0], AK);
    eep_mst_i.start();
    send(dev(1'h1), AK);
    foreach (rq[i]) begin
      expq.push_back(rq[i]);
      eep_mst_i.rd(i == rq.size() - 1);
    end
    eep_mst_i.stop();
  endtask : rd
  // bounded wait for the program cycle to start, then to end
  task automatic idle(input logic eb);
    int n;
    for (n = 0; n < 100 && o_busy !== 1'h1; n++) @(negedge i_ref_clk);
    `CHK(o_busy, eb)
    for (n = 0; n < P + 200 && o_busy !== 1'h0; n++) @(negedge i_ref_clk);
    `CHK(o_busy, 1'h0)
  endtask : idle
  initial begin
    failures = 0;
    num_checks = 0;
    i_resetn = 1'h0;
    i_write_protect = 1'h0;
    i_fast_mode = 1'h0;
    void'($urandom(36157));
    i_device_select_straps = 3'($urandom);
    // five cycles so the link side sees six edges
    repeat (5) @(negedge i_ref_clk);
    i_resetn = 1'h1;
    `CHK({o_sda_oe_n, o_busy, o_standby}, 3'h5)
    repeat (10) @(negedge i_ref_clk);
    eep_mst_i.o_scl = 1'h0;
    eep_mst_i.tick(10);
    send(dev(1'h0), NK);
    eep_mst_i.stop();
    for (int k = 0; k < 12; k++) begin
      i_fast_mode = 1'($urandom);
      eep_mst_i.start();
      if (k < 8) send({DT, 3'(k), 1'h0}, (3'(k) == i_device_select_straps) ? AK : NK);
      else send({DT ^ (4'h1 << (k - 8)), i_device_select_straps, 1'h0}, NK);
      eep_mst_i.stop();
    end
    $display("address test done");
    i_fast_mode = 1'h0;
    eep_mst_i.glitch = 1'h1;
    eep_mst_i.start();
    send(dev(1'h0), AK);
    eep_mst_i.stop();
    eep_mst_i.glitch = 1'h0;
    $display("glitch test done");
    v = 8'($urandom);
    eep_mst_i.start();
    send(dev(1'h0), AK);
    send(8'hFF, AK);
    send(8'h00, AK);
    send(v, AK);
    eep_mst_i.stop();
    eep_mst_i.start();
    send(dev(1'h0), NK);
    eep_mst_i.stop();
    idle(1'h1);
    rq = '{v};
    rd(13'h1F00);
    $display("byte write test done");
    i_write_protect = 1'h1;
    i_fast_mode = 1'h1;
    eep_mst_i.start();
    send(dev(1'h0), AK);
    send(8'h00, AK);
    send(8'h5E, AK);
    for (int k = 0; k < 34; k++) begin
      d[k] = 8'($urandom);
      send(d[k], AK);
    end
    eep_mst_i.stop();
    idle(1'h1);
    rq = {};
    for (int k = 0; k < 32; k++) rq.push_back(d[k + 2]);
    rd(13'h0040);
    $display("page test done");
    eep_mst_i.start();
    send(dev(1'h0), AK);
    send(8'h1F, AK);
    send(8'h00, AK);
    send(~v, NK);
    eep_mst_i.stop();
    idle(1'h0);
    rq = '{v};
    rd(13'h1F00);
    $display("protect test done");
    `CHK(expq.size(), 0)
    finish_test();
  end
endmodule : eep_i2c_slave_tb
`default_nettype wire
